/* oes_consts.svh */
// timing constants and reset values for the output enable sequencer
`ifndef OES_CONSTS_SVH
`define OES_CONSTS_SVH
// settling interval after enable, in nanoseconds
`define OES_SETTLE_NS 1000
// disable time after a latched enable fall, in nanoseconds
`define OES_DISABLE_NS 10
// clock period in nanoseconds (40 MHz)
`define OES_CLK_NS 25
// settle count, rounded down, at least one cycle
`define OES_SETTLE_CYC ((`OES_SETTLE_NS / `OES_CLK_NS) < 1 ? 1 : (`OES_SETTLE_NS / `OES_CLK_NS))
// disable count, rounded down, at least one cycle
`define OES_DISABLE_CYC ((`OES_DISABLE_NS / `OES_CLK_NS) < 1 ? 1 : (`OES_DISABLE_NS / `OES_CLK_NS))
// divider width and reset value
`define OES_DIV_W 4
`define OES_DIV_RST 4'h0
`endif

/* oes_pkg.sv */
// types for the output enable sequencer
package oes_pkg;
   // sequencer phases
   typedef enum logic [1:0] {
      OES_OFF,
      OES_SETTLE,
      OES_LOW,
      OES_RUN
   } oes_phase_t;
endpackage

/* oes_divider.sv */
// free running output divider with synchronous clear
`timescale 1ns/1ps
`default_nettype none
`include "oes_consts.svh"
module oes_divider #(
   parameter int W = `OES_DIV_W
) (
   // clock and clear
   input wire logic clk,
   input wire logic clr,
   // divider state
   output var logic [W-1:0] count
);
   // whole state of the divider
   typedef struct packed {
      logic [W-1:0] cnt;
   } oes_div_st_t;
   oes_div_st_t st;
   oes_div_st_t next_st;

   // next state: clear wins, else count up
   always_comb begin
      next_st = st;
      if (clr) begin
         next_st.cnt = W'(`OES_DIV_RST);
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   // register the state
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign count = st.cnt;
endmodule // oes_divider
`default_nettype wire

/* oes_sequencer.sv */
// enable sequencing and output driver control for a 1:3 clock fan-out
`timescale 1ns/1ps
`default_nettype none
`include "oes_consts.svh"
// Operation
// - enable low tristates all true/complement drivers
// - enable low ignores the select inputs
// - enable low holds flip-flops in reset
// - after enable rise, drive high while settling
// - after settling, drive all enabled outputs low
// - outputs follow only input clock edges
// - latched enable fall disables outputs promptly
// - enable and selects latched on input clock
// - unconnected enable or select reads high
// - single driver enable keeps divider running
// - single driver takes input clock level
// - complement is inverse of true output
module oes_sequencer #(
   parameter int SETTLE_CYC = `OES_SETTLE_CYC,
   parameter int DIV_W = `OES_DIV_W,
   parameter int NOUT = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control pins, with their pull-up presence flags
   input wire logic en_pin,
   input wire logic en_conn,
   input wire logic [2:0] sel_pin,
   input wire logic [2:0] sel_conn,
   // sampled reference clock level
   input wire logic ref_in,
   // differential output drivers
   output var logic [NOUT-1:0] y_true,
   output var logic [NOUT-1:0] y_comp,
   output var logic [NOUT-1:0] y_oe
);
   // whole state of the sequencer
   typedef struct packed {
      oes_pkg::oes_phase_t phase;
      logic en_q;
      logic [2:0] sel_q;
      logic [NOUT-1:0] drv_en;
      logic [NOUT-1:0] yt;
      logic [NOUT-1:0] yc;
      logic [NOUT-1:0] oe;
      logic [15:0] settle_cnt;
      logic ref_q;
   } oes_st_t;
   oes_st_t st;
   oes_st_t next_st;
   logic div_clr;
   logic [DIV_W-1:0] div_cnt;

   // decode the latched selects into per-driver enables; output mode
   // encoding is not covered, so a low select bit turns its driver off
   function automatic logic [NOUT-1:0] sel_to_en(input logic [2:0] s);
      logic [NOUT-1:0] r;
      r = '0;
      for (int i = 0; i < NOUT; i++) begin
         r[i] = s[i % 3];
      end
      return r;
   endfunction

   // divider kept, cleared on full enable
   assign div_clr = (st.phase != oes_pkg::OES_RUN);

   oes_divider #(.W(DIV_W)) u_div (
      .clk(clk),
      .clr(div_clr),
      .count(div_cnt)
   );

   // next-state logic
   always_comb begin
      logic en_v;
      logic [2:0] sel_v;
      logic [NOUT-1:0] want;
      logic [NOUT-1:0] lvl;
      en_v = 1'b0;
      sel_v = '0;
      want = '0;
      lvl = '0;
      next_st = st;
      en_v = en_conn ? en_pin : 1'b1;
      sel_v = sel_pin | ~sel_conn;
      next_st.en_q = en_v;
      next_st.sel_q = sel_v;
      next_st.ref_q = ref_in;
      // per-driver clock levels: driver 0 undivided, others divided
      for (int i = 0; i < NOUT; i++) begin
         lvl[i] = (i == 0) ? st.ref_q : div_cnt[0];
      end
      if (!st.en_q) begin
         // tristate and reset in the next cycle
         next_st.phase = oes_pkg::OES_OFF;
         next_st.oe = '0;
         next_st.yt = '0;
         next_st.yc = '0;
         next_st.drv_en = '0;
         next_st.settle_cnt = '0;
         next_st.sel_q = st.sel_q;
      end else begin
         unique case (st.phase)
            oes_pkg::OES_OFF: begin
               next_st.phase = oes_pkg::OES_SETTLE;
               next_st.oe = '1;
               next_st.yt = '1;
               next_st.yc = '0;
               next_st.settle_cnt = 16'(SETTLE_CYC - 1);
            end
            oes_pkg::OES_SETTLE: begin
               if (st.settle_cnt <= 16'h0001) begin
                  next_st.phase = oes_pkg::OES_LOW;
                  next_st.yt = '0;
                  next_st.yc = '1;
                  next_st.settle_cnt = '0;
               end else begin
                  next_st.settle_cnt = st.settle_cnt - 16'h0001;
               end
            end
            oes_pkg::OES_LOW: begin
               next_st.phase = oes_pkg::OES_RUN;
               next_st.drv_en = sel_to_en(st.sel_q);
               next_st.oe = sel_to_en(st.sel_q);
            end
            oes_pkg::OES_RUN: begin
               want = sel_to_en(st.sel_q);
               // a driver switched on here takes the live level at once, and
               // the divider is left running so divided outputs keep phase
               next_st.drv_en = want;
               next_st.oe = want;
               // follow the clock on each edge
               for (int i = 0; i < NOUT; i++) begin
                  next_st.yt[i] = want[i] ? lvl[i] : st.yt[i];
                  next_st.yc[i] = want[i] ? ~lvl[i] : st.yc[i];
               end
            end
         endcase
      end
      if (srst) begin
         next_st = '0;
      end
   end

   // register the state
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign y_true = st.yt;
   assign y_comp = st.yc;
   assign y_oe = st.oe;

   // the checks below watch the registered state and outputs in the same cycle or one edge apart;
   // all of them are idle while the synchronous reset is applied, so the
   // unknown state before the first reset edge never reaches them

   AST_OFF_TRISTATE: assert property (@(posedge clk) disable iff (srst)
      !st.en_q |=> (y_oe == '0))
      else $error("outputs not tristated after enable fall");

   AST_OFF_RESET: assert property (@(posedge clk) disable iff (srst)
      !st.en_q |=> (st.phase == oes_pkg::OES_OFF && st.drv_en == '0))
      else $error("state not reset while disabled");

   AST_DIV_CLEAR_OFF: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_OFF) |=> (div_cnt == '0))
      else $error("divider not held clear while disabled");

   AST_SEL_IGNORED: assert property (@(posedge clk) disable iff (srst)
      !st.en_q |=> $stable(st.sel_q))
      else $error("selects sampled while disabled");

   AST_SETTLE_ENTRY: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_OFF && st.en_q)
      |=> (st.phase == oes_pkg::OES_SETTLE && y_oe == '1 && y_true == '1))
      else $error("outputs not driven high after enable rise");

   AST_SETTLE_HIGH: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_SETTLE) |-> (y_true == '1 && y_oe == '1))
      else $error("outputs not high while settling");

   AST_SETTLE_EXIT: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_SETTLE && st.en_q && st.settle_cnt <= 16'h0001)
      |=> (st.phase == oes_pkg::OES_LOW && y_true == '0 && y_comp == '1))
      else $error("outputs not low when settling ends");

   AST_LOW_AFTER: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_LOW) |-> (y_true == '0))
      else $error("outputs not low after settling");

   AST_LOW_TO_RUN: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_LOW && st.en_q)
      |=> (st.phase == oes_pkg::OES_RUN && y_oe == sel_to_en($past(st.sel_q))))
      else $error("selected drivers not enabled after the low cycle");

   AST_COMP_INV: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_RUN) |-> ((y_comp & y_oe) == (~y_true & y_oe)))
      else $error("complement not inverse");

   AST_UNDIV_FOLLOW: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_RUN && st.en_q && st.sel_q[0])
      |=> (y_true[0] == $past(st.ref_q)))
      else $error("undivided output does not follow clock");

   AST_DIV_RESTART: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_LOW) |=> (div_cnt == '0))
      else $error("divider not restarted on full enable");

   AST_DIV_KEEP: assert property (@(posedge clk) disable iff (srst)
      (st.phase == oes_pkg::OES_RUN && $past(st.phase) == oes_pkg::OES_RUN)
      |-> (div_cnt == $past(div_cnt) + 1'b1))
      else $error("divider disturbed while running");

   AST_FLOAT_HIGH: assert property (@(posedge clk) disable iff (srst)
      !en_conn |=> st.en_q)
      else $error("floating enable not read high");
endmodule // oes_sequencer
`default_nettype wire

/* oes_ref_model.sv */
// reference clock source model for the output enable sequencer
`timescale 1ns/1ps
`default_nettype none
module oes_ref_model (
   // bench clock and start
   input wire logic clk,
   input wire logic run,
   // reference clock level
   output var logic ref_in
);
   logic [1:0] cnt; // half period counter
   // change off edge
   // the level moves on the falling edge, so it is stable around each latch edge;
   // a stopped source parks low and restarts its count from zero
   always @(negedge clk) begin
      if (!run) begin
         cnt <= 2'h0;
         ref_in <= 1'h0; // parked low while the source is stopped
      end else begin
         cnt <= cnt + 2'h1;
         if (cnt == 2'h3) begin
            ref_in <= ~ref_in; // slow square wave, four cycles a half
         end
      end
   end
endmodule // oes_ref_model
`default_nettype wire

/* tb_output_enable_sequencer.sv */
// self-checking bench for the output enable sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_output_enable_sequencer;
   logic clk = 1'h0; // 40 MHz clock
   logic srst = 1'h1; // held for 20 cycles
   logic en_pin = 1'h0;
   logic en_conn = 1'h1;
   logic [2:0] sel_pin = 3'h0;
   logic [2:0] sel_conn = 3'h7;
   logic ref_run = 1'h0; // starts the source model
   wire logic ref_in;
   logic [2:0] y_true, y_comp, y_oe;
   logic [3:0] hist = 4'h0; // recent reference levels
   logic [2:0] prev; // outputs one cycle back
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int i;
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
   always #12.5 clk = ~clk;
   oes_sequencer #(.SETTLE_CYC(4)) u_dut (.clk(clk), .srst(srst), .en_pin(en_pin),
      .en_conn(en_conn), .sel_pin(sel_pin), .sel_conn(sel_conn), .ref_in(ref_in),
      .y_true(y_true), .y_comp(y_comp), .y_oe(y_oe));
   oes_ref_model u_src (.clk(clk), .run(ref_run), .ref_in(ref_in));
   // hang guard, well above the some 125 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         test_done();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // selects swept while disabled must leave drivers off
   task automatic t_off();
      for (i = 0; i < 8; i++) begin
         sel_pin = i[2:0];
         tick(2);
         `CHK("oe_off", 3'h0, y_oe)
      end
   endtask
   // settle high, one low cycle, then run with the effective selects
   task automatic t_seq(input logic [2:0] s);
      for (i = 0; i < 12 && y_oe !== 3'h7; i++) tick(1);
      for (i = 0; i < 3; i++) begin
         `CHK("settle_hi", 3'h7, y_true)
         `CHK("settle_comp", 3'h0, y_comp)
         tick(1);
      end
      `CHK("low_true", 3'h0, y_true)
      `CHK("low_comp", 3'h7, y_comp)
      tick(1);
      `CHK("run_oe", s, y_oe)
      // divided outputs restart from a cleared divider: low first, then high
      tick(1);
      `CHK("div_start", 3'h0, y_true & s & 3'h6)
      tick(1);
      `CHK("div_phase", s & 3'h6, y_true & s & 3'h6)
   endtask
   task automatic t_on(input logic [2:0] s);
      en_pin = 1'h1;
      sel_pin = s;
      t_seq(s);
   endtask
   // output 0 shows the level latched one edge earlier; enabled divided
   // outputs toggle on every edge
   task automatic t_run(input logic [2:0] s);
      for (i = 0; i < 24; i++) begin
         prev = y_true;
         hist = {hist[2:0], ref_in};
         tick(1);
         `CHK("undiv", hist[0], y_true[0])
         `CHK("div", ~prev & s & 3'h6, y_true & s & 3'h6)
         `CHK("comp", ~y_true & y_oe, y_comp & y_oe)
      end
   endtask
   // drop output 0, then enable drivers while running: the divider keeps
   // its phase and output 0 picks up the live reference level at once
   task automatic t_single();
      sel_pin = 3'h4;
      tick(3);
      `CHK("drop_oe", 3'h4, y_oe)
      sel_pin = 3'h7;
      for (i = 0; i < 2; i++) begin
         prev = y_true;
         hist = {hist[2:0], ref_in};
         tick(1);
         `CHK("single_div", ~prev[2], y_true[2])
      end
      `CHK("single_undiv", hist[0], y_true[0])
      `CHK("single_oe", 3'h7, y_oe)
      `CHK("single_div", y_true[2], y_true[1])
   endtask
   // floating enable and select bit 1 read high through the pull-ups
   task automatic t_float();
      en_conn = 1'h0;
      sel_conn = 3'h5;
      sel_pin = 3'h1;
      t_seq(3'h3);
      t_run(3'h3);
   endtask
   // latched enable fall turns drivers off on the next edge
   task automatic t_fall();
      en_pin = 1'h0;
      tick(2);
      `CHK("fall_oe", 3'h0, y_oe)
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      tick(20);
      srst = 1'h0;
      tick(1);
      t_off();
      ref_run = 1'h1;
      t_on(3'h5);
      t_run(3'h5);
      t_single();
      t_fall();
      t_off();
      t_float();
      test_done();
   end
endmodule // tb_output_enable_sequencer
`default_nettype wire
